//--- rtl/fri_map.svh
`ifndef FRI_MAP_SVH
`define FRI_MAP_SVH

// register byte offsets
`define FRI_OFF_INSTR 8'h00
`define FRI_OFF_ACC 8'h04
`define FRI_OFF_LATCH 8'h08
`define FRI_OFF_PC 8'h0C
`define FRI_OFF_STATUS 8'h10
`define FRI_OFF_FADDR 8'h14
`define FRI_OFF_FDATA 8'h18

// instruction word encodings
`define FRI_OPC_INVERT 6'h09
`define FRI_OPC_DEC 6'h03
`define FRI_OPC_INC 6'h0A
`define FRI_OPC_DECSZ 6'h0B
`define FRI_OPC_INCSZ 6'h0F
`define FRI_BR_TAG 3'h5
`define FRI_BR_TAG_HI 13
`define FRI_BR_TAG_LO 11
`define FRI_BR_K_HI 10

// field positions
`define FRI_ST_ZERO 0
`define FRI_ST_BUSY 1
`define FRI_ST_SKIP 2
`define FRI_LATCH_SEL_HI 4
`define FRI_LATCH_SEL_LO 3

// reset values
`define FRI_RST_ACC 8'h00
`define FRI_RST_LATCH 5'h00
`define FRI_RST_PC 13'h0000
`define FRI_RST_INSTR 14'h0000
`define FRI_RST_FADDR 7'h00

`endif

//--- rtl/fri_pkg.sv
package fri_pkg;

    typedef enum logic [2:0] {
        FRI_IDLE = 3'b001,
        FRI_EXEC = 3'b010,
        FRI_SECOND = 3'b100
    } fri_state_t;

    typedef enum logic [1:0] {
        FRI_ALU_PASS = 2'h0,
        FRI_ALU_INV = 2'h1,
        FRI_ALU_DEC = 2'h2,
        FRI_ALU_INC = 2'h3
    } fri_alu_op_t;

    typedef struct packed {
        logic [5:0] opc;
        logic dest;
        logic [6:0] faddr;
    } fri_instr_t;

    typedef struct packed {
        logic [7:0] value;
        logic zero;
    } fri_alu_res_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } fri_wb_req_t;

endpackage

//--- rtl/fri_alu.sv
`timescale 1ns/1ps
module fri_alu (
    input wire fri_pkg::fri_alu_op_t op_i,
    input wire logic [7:0] operand_i,
    output fri_pkg::fri_alu_res_t res_o
);

    logic [7:0] value;

    // arithmetic wraps modulo 256
    always_comb begin
        case (op_i)
            fri_pkg::FRI_ALU_INV: value = ~operand_i;
            fri_pkg::FRI_ALU_DEC: value = 8'(operand_i - 8'h01); // RQ11
            fri_pkg::FRI_ALU_INC: value = 8'(operand_i + 8'h01); // RQ11
            default: value = operand_i;
        endcase
        res_o.value = value;
        res_o.zero = (value == 8'h00);
    end

endmodule

//--- rtl/fri_exec.sv
// Operation
// RQ1 - invert file register, route by destination, Z
// RQ2 - branch loads 11-bit immediate into PC[10:0]
// RQ3 - branch copies latch bits 4:3 into PC[12:11]
// RQ4 - branch always taken, flags kept, two cycles
// RQ5 - decrement file register, route by destination, Z
// RQ6 - increment file register, route by destination, Z
// RQ7 - decrement, store, flags kept, skip on zero
// RQ8 - increment, store, flags kept, skip on zero
// RQ9 - skipped instruction replaced by a no-op
// RQ10 - 7-bit file address, 1-bit destination
// RQ11 - increment and decrement wrap modulo 256
// RQ12 - non-branch, non-skipping instructions take one cycle
`timescale 1ns/1ps
`include "fri_map.svh"
module fri_exec #(
    parameter int FILE_DEPTH = 128
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [12:0] pc_o,
    output logic zero_o
);

    fri_pkg::fri_wb_req_t req;
    fri_pkg::fri_state_t state_q, state_d;
    fri_pkg::fri_instr_t instr_q, instr_d;
    fri_pkg::fri_alu_op_t alu_op;
    fri_pkg::fri_alu_res_t alu_res;
    logic [7:0] acc_q, acc_d;
    logic [4:0] latch_q, latch_d;
    logic [12:0] pc_q, pc_d;
    logic [6:0] faddr_q, faddr_d;
    logic zero_q, zero_d;
    logic skip_q, skip_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic [7:0] mem_q [FILE_DEPTH];
    logic mem_we;
    logic [6:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] op_val;
    logic bus_wr;
    logic [31:0] wr_val;
    logic is_br;

    function automatic logic [31:0] fri_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic fri_is_branch(input fri_pkg::fri_instr_t i);
        logic [13:0] w;
        w = i;
        return w[`FRI_BR_TAG_HI:`FRI_BR_TAG_LO] == `FRI_BR_TAG;
    endfunction

    function automatic logic fri_is_skip(input fri_pkg::fri_instr_t i);
        return (i.opc == `FRI_OPC_DECSZ) || (i.opc == `FRI_OPC_INCSZ);
    endfunction

    function automatic fri_pkg::fri_alu_op_t fri_op_of(
            input fri_pkg::fri_instr_t i);
        fri_pkg::fri_alu_op_t o;
        case (i.opc)
            `FRI_OPC_INVERT: o = fri_pkg::FRI_ALU_INV;
            `FRI_OPC_DEC, `FRI_OPC_DECSZ: o = fri_pkg::FRI_ALU_DEC;
            `FRI_OPC_INC, `FRI_OPC_INCSZ: o = fri_pkg::FRI_ALU_INC;
            default: o = fri_pkg::FRI_ALU_PASS;
        endcase
        return o;
    endfunction

    function automatic logic fri_known(input fri_pkg::fri_instr_t i);
        return fri_op_of(i) != fri_pkg::FRI_ALU_PASS;
    endfunction

    assign req.cyc = wb_cyc_i;
    assign req.stb = wb_stb_i;
    assign req.we = wb_we_i;
    assign req.sel = wb_sel_i;
    assign req.adr = wb_adr_i;
    assign req.dat = wb_dat_i;

    // file operand and destination come straight from the word
    assign op_val = mem_q[instr_q.faddr]; // RQ10
    assign alu_op = fri_op_of(instr_q);
    assign is_br = fri_is_branch(instr_q);

    fri_alu u_alu (
        .op_i(alu_op),
        .operand_i(op_val),
        .res_o(alu_res)
    );

    // bus writes land at the edge that sees ack high
    assign bus_wr = ack_q && req.cyc && req.stb && req.we;

    always_comb begin
        wr_val = 32'h0000_0000;
        case (req.adr)
            `FRI_OFF_INSTR: wr_val = fri_merge({18'h00000, instr_q},
                                               req.dat, req.sel);
            `FRI_OFF_ACC: wr_val = fri_merge({24'h000000, acc_q},
                                             req.dat, req.sel);
            `FRI_OFF_LATCH: wr_val = fri_merge({27'h0000000, latch_q},
                                               req.dat, req.sel);
            `FRI_OFF_STATUS: wr_val = fri_merge({31'h00000000, zero_q},
                                                req.dat, req.sel);
            `FRI_OFF_FADDR: wr_val = fri_merge({25'h0000000, faddr_q},
                                               req.dat, req.sel);
            `FRI_OFF_FDATA: wr_val = fri_merge({24'h000000,
                                                mem_q[faddr_q]},
                                               req.dat, req.sel);
            default: wr_val = 32'h0000_0000;
        endcase
    end

    // bus slave: answers only while the core is idle
    always_comb begin
        ack_d = req.cyc && req.stb && !ack_q
                && (state_q == fri_pkg::FRI_IDLE);
        dat_d = dat_q;
        if (ack_d && !req.we) begin
            case (req.adr)
                `FRI_OFF_INSTR: dat_d = {18'h00000, instr_q};
                `FRI_OFF_ACC: dat_d = {24'h000000, acc_q};
                `FRI_OFF_LATCH: dat_d = {27'h0000000, latch_q};
                `FRI_OFF_PC: dat_d = {19'h00000, pc_q};
                `FRI_OFF_STATUS: dat_d = {29'h00000000, skip_q,
                                          1'b0, zero_q};
                `FRI_OFF_FADDR: dat_d = {25'h0000000, faddr_q};
                `FRI_OFF_FDATA: dat_d = {24'h000000, mem_q[faddr_q]};
                default: dat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    // execution sequencer and architectural state
    always_comb begin
        state_d = state_q;
        instr_d = instr_q;
        acc_d = acc_q;
        latch_d = latch_q;
        pc_d = pc_q;
        faddr_d = faddr_q;
        zero_d = zero_q;
        skip_d = skip_q;
        mem_we = 1'b0;
        mem_waddr = instr_q.faddr;
        mem_wdata = alu_res.value;
        case (state_q)
            fri_pkg::FRI_IDLE: begin
                if (bus_wr) begin
                    case (req.adr)
                        `FRI_OFF_INSTR: begin
                            instr_d = wr_val[13:0];
                            state_d = fri_pkg::FRI_EXEC;
                        end
                        `FRI_OFF_ACC: acc_d = wr_val[7:0];
                        `FRI_OFF_LATCH: latch_d = wr_val[4:0];
                        `FRI_OFF_STATUS: zero_d = wr_val[`FRI_ST_ZERO];
                        `FRI_OFF_FADDR: faddr_d = wr_val[6:0];
                        `FRI_OFF_FDATA: begin
                            mem_we = 1'b1;
                            mem_waddr = faddr_q;
                            mem_wdata = wr_val[7:0];
                        end
                        default: state_d = fri_pkg::FRI_IDLE;
                    endcase
                end
            end
            fri_pkg::FRI_EXEC: begin
                state_d = fri_pkg::FRI_IDLE; // RQ12
                pc_d = 13'(pc_q + 13'h0001);
                if (skip_q) begin
                    skip_d = 1'b0; // RQ9
                end else if (is_br) begin
                    pc_d = {latch_q[`FRI_LATCH_SEL_HI:`FRI_LATCH_SEL_LO],
                            instr_q[`FRI_BR_K_HI:0]}; // RQ2 RQ3
                    state_d = fri_pkg::FRI_SECOND; // RQ4
                end else if (fri_known(instr_q)) begin
                    if (instr_q.dest) begin
                        mem_we = 1'b1; // RQ1 RQ5 RQ6 RQ7 RQ8
                    end else begin
                        acc_d = alu_res.value; // RQ1 RQ5 RQ6 RQ7 RQ8
                    end
                    if (fri_is_skip(instr_q)) begin
                        skip_d = alu_res.zero; // RQ7 RQ8
                    end else begin
                        zero_d = alu_res.zero; // RQ1 RQ5 RQ6
                    end
                end
            end
            fri_pkg::FRI_SECOND: state_d = fri_pkg::FRI_IDLE; // RQ4
            default: state_d = fri_pkg::FRI_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= fri_pkg::FRI_IDLE;
            instr_q <= `FRI_RST_INSTR;
            acc_q <= `FRI_RST_ACC;
            latch_q <= `FRI_RST_LATCH;
            pc_q <= `FRI_RST_PC;
            faddr_q <= `FRI_RST_FADDR;
            zero_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            state_q <= state_d;
            instr_q <= instr_d;
            acc_q <= acc_d;
            latch_q <= latch_d;
            pc_q <= pc_d;
            faddr_q <= faddr_d;
            zero_q <= zero_d;
            skip_q <= skip_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem_q[mem_waddr] <= mem_wdata;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign pc_o = pc_q;
    assign zero_o = zero_q;

    // checks
    logic ex_live;
    assign ex_live = (state_q == fri_pkg::FRI_EXEC) && !skip_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_invert_to_acc: // RQ1
    assert property (ex_live && instr_q.opc == `FRI_OPC_INVERT
                     && !instr_q.dest
                     |=> acc_q == ~$past(op_val)
                         && zero_q == (acc_q == 8'h00))
        else $error("invert result wrong");

    a_branch_low_bits: // RQ2
    assert property (ex_live && is_br
                     |=> pc_q[10:0] == $past(instr_q[10:0]))
        else $error("branch target low bits wrong");

    a_branch_high_bits: // RQ3
    assert property (ex_live && is_br
                     |=> pc_q[12:11] == $past(latch_q[4:3]))
        else $error("branch page bits wrong");

    a_branch_two_cycles: // RQ4
    assert property (ex_live && is_br
                     |=> state_q == fri_pkg::FRI_SECOND && $stable(zero_q)
                     ##1 state_q == fri_pkg::FRI_IDLE && $stable(pc_q))
        else $error("branch timing or flags wrong");

    a_dec_to_acc: // RQ5
    assert property (ex_live && instr_q.opc == `FRI_OPC_DEC
                     && !instr_q.dest
                     |=> acc_q == 8'($past(op_val) - 8'h01)
                         && zero_q == (acc_q == 8'h00))
        else $error("decrement result wrong");

    a_inc_to_file: // RQ6
    assert property (ex_live && instr_q.opc == `FRI_OPC_INC
                     && instr_q.dest
                     |=> mem_q[$past(instr_q.faddr)]
                         == 8'($past(op_val) + 8'h01)
                         && $stable(acc_q))
        else $error("increment to file wrong");

    a_decsz_skip_flag: // RQ7
    assert property (ex_live && instr_q.opc == `FRI_OPC_DECSZ
                     |=> $stable(zero_q)
                         && skip_q == ($past(op_val) == 8'h01))
        else $error("decrement skip wrong");

    a_incsz_skip_flag: // RQ8
    assert property (ex_live && instr_q.opc == `FRI_OPC_INCSZ
                     |=> $stable(zero_q)
                         && skip_q == ($past(op_val) == 8'hFF))
        else $error("increment skip wrong");

    a_skip_makes_nop: // RQ9
    assert property (state_q == fri_pkg::FRI_EXEC && skip_q
                     |=> !skip_q && $stable(acc_q) && $stable(zero_q)
                         && pc_q == 13'($past(pc_q) + 13'h0001))
        else $error("skipped slot not a no-op");

    a_inc_wraps: // RQ11
    assert property (ex_live && instr_q.opc == `FRI_OPC_INC
                     && !instr_q.dest && op_val == 8'hFF
                     |=> acc_q == 8'h00 && zero_q)
        else $error("increment does not wrap");

    a_single_cycle: // RQ12
    assert property (ex_live && !is_br
                     |=> state_q == fri_pkg::FRI_IDLE)
        else $error("instruction longer than one cycle");

    c_branch: cover property (ex_live && is_br);
    c_skip_taken: cover property (state_q == fri_pkg::FRI_EXEC && skip_q);
    c_dec_wrap: cover property (ex_live && alu_op == fri_pkg::FRI_ALU_DEC
                                && op_val == 8'h00);
    c_bus_read: cover property (wb_ack_o && !wb_we_i);

endmodule

//--- dv/fri_exec_tb.sv
`timescale 1ns/1ps
`include "fri_map.svh"
`define CHK(nm, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            $display("ERROR %s expected %0h seen %0h", nm, e, g); \
            bad_count++; \
        end \
    end
module fri_exec_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [12:0] pc_o;
    logic zero_o;
    int bad_count = 0;
    int comparisons = 0;
    logic [12:0] ep = 13'h0000;
    logic [31:0] q;
    int n1;
    int n2;

    always #2 clk_i = ~clk_i;

    fri_exec dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pc_o(pc_o), .zero_o(zero_o)
    );

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one classic cycle; holds the request until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output int n);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (n = 1; n <= 40; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (n > 40) begin
            $display("ERROR ack expected 1 seen 0");
            bad_count++;
            end_sim();
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        int n;
        bus(1'b1, a, d, r, n);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r,
                      output int n);
        bus(1'b0, a, 32'h0000_0000, r, n);
    endtask

    task automatic chkreg(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        logic [31:0] r;
        int n;
        rd(a, r, n);
        `CHK(nm, e, r)
    endtask

    // load one file register through the address and data windows
    task automatic ld(input logic [6:0] f, input logic [7:0] v);
        wr(`FRI_OFF_FADDR, {25'h0, f});
        wr(`FRI_OFF_FDATA, {24'h0, v});
    endtask

    task automatic ex(input logic [5:0] o, input logic d,
                      input logic [6:0] f);
        wr(`FRI_OFF_INSTR, {18'h0, o, d, f});
        ep = ep + 13'h0001;
    endtask

    task automatic br(input logic [10:0] k);
        wr(`FRI_OFF_INSTR, {18'h0, `FRI_BR_TAG, k});
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        chkreg("acc rst", `FRI_OFF_ACC, 32'h0);
        chkreg("latch rst", `FRI_OFF_LATCH, 32'h0);
        chkreg("status rst", `FRI_OFF_STATUS, 32'h0);
        chkreg("unmapped", 8'h1C, 32'h0);
        wr(`FRI_OFF_PC, 32'h0000_1234);
        chkreg("pc ro", `FRI_OFF_PC, 32'h0);
        ld(7'h7F, 8'hFF);
        ex(`FRI_OPC_INC, 1'b1, 7'h7F);
        chkreg("inc wrap", `FRI_OFF_FDATA, 32'h0);
        `CHK("inc zero", 1'b1, zero_o)
        ld(7'h00, 8'h00);
        ex(`FRI_OPC_DEC, 1'b0, 7'h00);
        chkreg("dec acc", `FRI_OFF_ACC, 32'hFF);
        chkreg("dec file", `FRI_OFF_FDATA, 32'h0);
        `CHK("dec zero", 1'b0, zero_o)
        ld(7'h01, 8'h5A);
        ex(`FRI_OPC_INVERT, 1'b0, 7'h01);
        chkreg("inv acc", `FRI_OFF_ACC, 32'hA5);
        ld(7'h01, 8'hFF);
        ex(`FRI_OPC_INVERT, 1'b1, 7'h01);
        chkreg("inv file", `FRI_OFF_FDATA, 32'h0);
        `CHK("inv zero", 1'b1, zero_o)
        ld(7'h06, 8'hFF);
        ex(`FRI_OPC_INC, 1'b0, 7'h06);
        chkreg("inc acc wrap", `FRI_OFF_ACC, 32'h0);
        `CHK("inc acc zero", 1'b1, zero_o)
        ld(7'h02, 8'h7F);
        ex(`FRI_OPC_INC, 1'b0, 7'h02);
        rd(`FRI_OFF_ACC, q, n1);
        `CHK("inc acc", 32'h80, q)
        `CHK("pc step", ep, pc_o)
        // branch: flags kept, one cycle longer than a plain op
        wr(`FRI_OFF_STATUS, 32'h1);
        wr(`FRI_OFF_LATCH, 32'h18);
        br(11'h7FF);
        rd(`FRI_OFF_ACC, q, n2);
        `CHK("br pc", 13'h1FFF, pc_o)
        `CHK("br zero", 1'b1, zero_o)
        `CHK("br cycles", n1 + 1, n2)
        wr(`FRI_OFF_LATCH, 32'h10);
        br(11'h2AA);
        chkreg("latch rw", `FRI_OFF_LATCH, 32'h10);
        `CHK("br pc2", 13'h12AA, pc_o)
        ep = 13'h12AA;
        // decrement to zero sets a skip, next op is discarded
        wr(`FRI_OFF_STATUS, 32'h0);
        ld(7'h03, 8'h01);
        ex(`FRI_OPC_DECSZ, 1'b1, 7'h03);
        chkreg("decsz file", `FRI_OFF_FDATA, 32'h0);
        chkreg("decsz stat", `FRI_OFF_STATUS, 32'h4);
        ld(7'h03, 8'h10);
        ex(`FRI_OPC_INC, 1'b1, 7'h03);
        chkreg("skipped", `FRI_OFF_FDATA, 32'h10);
        chkreg("skip clr", `FRI_OFF_STATUS, 32'h0);
        `CHK("skip pc", ep, pc_o)
        // increment wraps to zero into acc, zero flag left alone
        wr(`FRI_OFF_STATUS, 32'h1);
        ld(7'h04, 8'hFF);
        ex(`FRI_OPC_INCSZ, 1'b0, 7'h04);
        chkreg("incsz acc", `FRI_OFF_ACC, 32'h0);
        chkreg("incsz stat", `FRI_OFF_STATUS, 32'h5);
        ex(`FRI_OPC_DEC, 1'b0, 7'h04);
        chkreg("skipped2", `FRI_OFF_ACC, 32'h0);
        // nonzero skip results do not skip
        ld(7'h05, 8'h05);
        ex(`FRI_OPC_INCSZ, 1'b1, 7'h05);
        chkreg("incsz nz", `FRI_OFF_STATUS, 32'h1);
        ex(`FRI_OPC_DEC, 1'b1, 7'h05);
        chkreg("next runs", `FRI_OFF_FDATA, 32'h05);
        ex(`FRI_OPC_DECSZ, 1'b0, 7'h05);
        chkreg("decsz nz", `FRI_OFF_STATUS, 32'h0);
        chkreg("decsz acc", `FRI_OFF_ACC, 32'h04);
        `CHK("pc end", ep, pc_o)
        end_sim();
    end
endmodule
